// [verilog/csp_pkg.sv]
// Overview of operation
// - Special-trigger mode: a match resets the Timer1 count and starts an enabled conversion.
// - Special-trigger mode never drives the output pin.
// - Trigger output asserts in the cycle the Timer1 count equals the compare pair.
// - Timer1 clears on its next clock tick after the match, not at it.
// - A trigger-caused Timer1 clear never sets the Timer1 overflow flag.
// - If the compare pair changes so the match is gone, the Timer1 clear is skipped.
// - Compare and timers depend on the system clock and stop during sleep.
// - PWM mode drives a pulse-width waveform with up to 10 bits of resolution.
// - Pin drives only with direction bit clear; zero control register releases the pin.
// - PWM period is (period value + 1) times 4 Tosc times prescale ratio.
// - Step after count equals period: clear count, set pin unless duty 0, load duty.
// - The Timer2 postscaler never changes the PWM period.
// - Duty value is compare low register as MSBs and duty low bits as LSBs.
// - Duty writes are taken anytime but only used at the next period match.
// - In PWM mode the compare high register is read-only to software.
// - Active duty is held in compare high plus a hidden 2-bit latch.
// - Time base is Timer2 count joined with two oscillator or prescaler bits.
// - When the time base equals the active duty, the pin goes low.
// - High time equals duty times Tosc times prescale ratio.
// - A mode field of zero turns the unit off and resets its internal state.
package csp_pkg;

  // Register offsets
  localparam logic [3:0] CSP_OFF_CTRL = 4'h0;
  localparam logic [3:0] CSP_OFF_CMP_LO = 4'h1;
  localparam logic [3:0] CSP_OFF_CMP_HI = 4'h2;
  localparam logic [3:0] CSP_OFF_T1_LO = 4'h3;
  localparam logic [3:0] CSP_OFF_T1_HI = 4'h4;
  localparam logic [3:0] CSP_OFF_T2_CNT = 4'h5;
  localparam logic [3:0] CSP_OFF_PERIOD = 4'h6;
  localparam logic [3:0] CSP_OFF_T2_CTRL = 4'h7;
  localparam logic [3:0] CSP_OFF_FLAGS = 4'h8;
  localparam logic [3:0] CSP_OFF_AUX = 4'h9;

  // Field positions
  localparam int CSP_CTRL_DUTY_LSB = 4;
  localparam int CSP_T2_RUN_BIT = 2;
  localparam int CSP_T2_POST_LSB = 3;
  localparam int CSP_FLAG_T1_OVF = 0;
  localparam int CSP_FLAG_T2_MATCH = 1;
  localparam int CSP_AUX_T1_RUN = 0;
  localparam int CSP_AUX_PIN_DIR = 1;

  // Reset values
  localparam logic [7:0] CSP_RST_ZERO = 8'h00;
  localparam logic [7:0] CSP_RST_PERIOD = 8'hff;
  localparam logic [7:0] CSP_RST_AUX = 8'h02;

  // Timing: one oscillator period per sys_clk, four per instruction step
  localparam int CSP_CLK_NS = 50;
  localparam int CSP_TOSC_NS = 50;
  localparam int CSP_TOSC_CYC = (CSP_TOSC_NS + CSP_CLK_NS - 1) / CSP_CLK_NS;
  localparam logic [1:0] CSP_INSTR_LAST = 2'h3;

  // Unit modes kept by this block
  typedef enum logic [3:0] {
    CSP_MODE_OFF = 4'h0,
    CSP_MODE_SPECIAL = 4'hb,
    CSP_MODE_PWM = 4'hc
  } csp_mode_t;

  // Timer2 prescale selections
  typedef enum logic [1:0] {
    CSP_PRE_1 = 2'h0,
    CSP_PRE_4 = 2'h1,
    CSP_PRE_16 = 2'h2
  } csp_pre_t;

endpackage

// [verilog/csp_unit.sv]
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module csp_unit
  import csp_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Chip context
  input wire logic sleepMode,
  input wire logic adcEnabled,
  // Trigger events
  output logic specialTrigger,
  output logic adcStart,
  // Output pin
  output logic pinOut,
  output logic pinOe
);

  // Write decode, shared by every register
  function automatic logic wrHit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    wrHit = (a == ADDR_W'(off));
  endfunction

  // Terminal count of the Fosc prescaler: 4 * ratio - 1
  function automatic logic [5:0] preLast(input logic [1:0] sel);
    if (sel == CSP_PRE_1) begin
      preLast = 6'h03;
    end else if (sel == CSP_PRE_4) begin
      preLast = 6'h0f;
    end else begin
      preLast = 6'h3f;
    end
  endfunction

  // PWM when both upper mode bits are set
  function automatic logic isPwm(input logic [3:0] m);
    isPwm = (m[3:2] == 2'b11);
  endfunction

  logic [3:0] unitMode_reg;
  logic [1:0] dutyLowBits_reg;
  logic [7:0] cmpLow_reg;
  logic [7:0] cmpHigh_reg;
  logic [15:0] t1Count_reg;
  logic [1:0] t1Div_reg;
  logic [7:0] t2Count_reg;
  logic [5:0] t2Pre_reg;
  logic [7:0] period_reg;
  logic [1:0] t2PreSel_reg;
  logic t2Run_reg;
  logic [3:0] t2PostSel_reg;
  logic [3:0] t2PostCnt_reg;
  logic t1Ovf_reg;
  logic t2Match_reg;
  logic t1Run_reg;
  logic pinDir_reg;
  logic [1:0] dutyLatch_reg;
  logic pwmLevel_reg;

  logic pwmMode;
  logic specialMode;
  logic t1Tick;
  logic t2Step;
  logic periodReload;
  logic postDone;
  logic [9:0] dutyNext;
  logic [9:0] activeDuty;
  logic [9:0] timeBase;
  logic [1:0] baseLow;
  logic t1Wrap;
  logic baseStep;

  assign pwmMode = isPwm(unitMode_reg);
  assign specialMode = (unitMode_reg == CSP_MODE_SPECIAL);
  assign dutyNext = {cmpLow_reg, dutyLowBits_reg};
  assign activeDuty = {cmpHigh_reg, dutyLatch_reg};

  // Trigger is combinational so it rises in the matching cycle
  assign specialTrigger = specialMode && !sleepMode &&
                          (t1Count_reg == {cmpHigh_reg, cmpLow_reg});
  assign adcStart = specialTrigger && adcEnabled;

  // Timer1 runs on the instruction rate, halted in sleep
  assign t1Tick = t1Run_reg && !sleepMode && (t1Div_reg == CSP_INSTR_LAST);
  assign t1Wrap = t1Tick && !specialTrigger && (t1Count_reg == 16'hffff);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !t1Run_reg) begin
      t1Div_reg <= 2'h0;
    end else if (!sleepMode) begin
      t1Div_reg <= t1Div_reg + 2'h1;
    end
  end

  // Timer1 count; a held match clears it on the next tick only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      t1Count_reg <= 16'h0000;
    end else if (regWr && wrHit(regAddr, CSP_OFF_T1_LO)) begin
      t1Count_reg[7:0] <= regWrData;
    end else if (regWr && wrHit(regAddr, CSP_OFF_T1_HI)) begin
      t1Count_reg[15:8] <= regWrData;
    end else if (t1Tick) begin
      if (specialTrigger) begin
        t1Count_reg <= 16'h0000;
      end else begin
        t1Count_reg <= t1Count_reg + 16'h0001;
      end
    end
  end

  // Timer2 prescaler counts Fosc cycles; a count write restarts it
  assign t2Step = t2Run_reg && !sleepMode && (t2Pre_reg == preLast(t2PreSel_reg));
  assign periodReload = t2Step && (t2Count_reg == period_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !t2Run_reg || (regWr && wrHit(regAddr, CSP_OFF_T2_CNT))) begin
      t2Pre_reg <= 6'h00;
    end else if (t2Step) begin
      t2Pre_reg <= 6'h00;
    end else if (!sleepMode) begin
      t2Pre_reg <= t2Pre_reg + 6'h01;
    end
  end

  // Timer2 count wraps at the period value
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      t2Count_reg <= 8'h00;
    end else if (regWr && wrHit(regAddr, CSP_OFF_T2_CNT)) begin
      t2Count_reg <= regWrData;
    end else if (periodReload) begin
      t2Count_reg <= 8'h00;
    end else if (t2Step) begin
      t2Count_reg <= t2Count_reg + 8'h01;
    end
  end

  // Postscaler only paces the match flag, never the period
  assign postDone = periodReload && (t2PostCnt_reg == t2PostSel_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || postDone) begin
      t2PostCnt_reg <= 4'h0;
    end else if (periodReload) begin
      t2PostCnt_reg <= t2PostCnt_reg + 4'h1;
    end
  end

  // Low time-base bits follow the prescaler stage of the chosen ratio
  always_comb begin
    if (t2PreSel_reg == CSP_PRE_1) begin
      baseLow = t2Pre_reg[1:0];
    end else if (t2PreSel_reg == CSP_PRE_4) begin
      baseLow = t2Pre_reg[3:2];
    end else begin
      baseLow = t2Pre_reg[5:4];
    end
  end
  assign timeBase = {t2Count_reg, baseLow};

  // Time base steps on the coming edge; the pin flop looks one step ahead.
  // A registered compare against the present value would stretch every
  // pulse by one time-base step, so the clear is timed to land on the step.
  always_comb begin
    if (!t2Run_reg || sleepMode) begin
      baseStep = 1'b0;
    end else if (t2PreSel_reg == CSP_PRE_1) begin
      baseStep = 1'b1;
    end else if (t2PreSel_reg == CSP_PRE_4) begin
      baseStep = (t2Pre_reg[1:0] == 2'h3);
    end else begin
      baseStep = (t2Pre_reg[3:0] == 4'hf);
    end
  end

  // Control and compare registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      unitMode_reg <= CSP_MODE_OFF;
      dutyLowBits_reg <= 2'h0;
      cmpLow_reg <= CSP_RST_ZERO;
      period_reg <= CSP_RST_PERIOD;
      t2PreSel_reg <= CSP_PRE_1;
      t2Run_reg <= 1'b0;
      t2PostSel_reg <= 4'h0;
      t1Run_reg <= 1'b0;
      pinDir_reg <= CSP_RST_AUX[CSP_AUX_PIN_DIR];
    end else if (regWr) begin
      if (wrHit(regAddr, CSP_OFF_CTRL)) begin
        unitMode_reg <= regWrData[3:0];
        dutyLowBits_reg <= regWrData[CSP_CTRL_DUTY_LSB +: 2];
      end else if (wrHit(regAddr, CSP_OFF_CMP_LO)) begin
        cmpLow_reg <= regWrData;
      end else if (wrHit(regAddr, CSP_OFF_PERIOD)) begin
        period_reg <= regWrData;
      end else if (wrHit(regAddr, CSP_OFF_T2_CTRL)) begin
        t2PreSel_reg <= regWrData[1:0];
        t2Run_reg <= regWrData[CSP_T2_RUN_BIT];
        t2PostSel_reg <= regWrData[CSP_T2_POST_LSB +: 4];
      end else if (wrHit(regAddr, CSP_OFF_AUX)) begin
        t1Run_reg <= regWrData[CSP_AUX_T1_RUN];
        pinDir_reg <= regWrData[CSP_AUX_PIN_DIR];
      end
    end
  end

  // Compare high: software owned outside PWM, duty buffer inside it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmpHigh_reg <= CSP_RST_ZERO;
    end else if (pwmMode) begin
      if (periodReload) begin
        cmpHigh_reg <= cmpLow_reg;
      end
    end else if (regWr && wrHit(regAddr, CSP_OFF_CMP_HI)) begin
      cmpHigh_reg <= regWrData;
    end
  end

  // Hidden duty LSB latch and PWM level
  always_ff @(posedge sys_clk) begin
    if (sys_rst || unitMode_reg == CSP_MODE_OFF || !pwmMode) begin
      dutyLatch_reg <= 2'h0;
      pwmLevel_reg <= 1'b0;
    end else if (periodReload) begin
      dutyLatch_reg <= dutyLowBits_reg;
      pwmLevel_reg <= (dutyNext != 10'h000);
    end else if (baseStep && (timeBase == activeDuty - 10'h001)) begin
      pwmLevel_reg <= 1'b0;
    end
  end

  // Sticky flags; a set in the same cycle beats the write-one clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      t1Ovf_reg <= 1'b0;
      t2Match_reg <= 1'b0;
    end else begin
      if (t1Wrap) begin
        t1Ovf_reg <= 1'b1;
      end else if (regWr && wrHit(regAddr, CSP_OFF_FLAGS) && regWrData[CSP_FLAG_T1_OVF]) begin
        t1Ovf_reg <= 1'b0;
      end
      if (postDone) begin
        t2Match_reg <= 1'b1;
      end else if (regWr && wrHit(regAddr, CSP_OFF_FLAGS) &&
                   regWrData[CSP_FLAG_T2_MATCH]) begin
        t2Match_reg <= 1'b0;
      end
    end
  end

  // Pin drives only in PWM with the direction bit clear
  assign pinOut = pwmLevel_reg;
  assign pinOe = pwmMode && !pinDir_reg;

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= CSP_RST_ZERO;
    end else if (regRd) begin
      if (wrHit(regAddr, CSP_OFF_CTRL)) begin
        regRdData <= {2'b00, dutyLowBits_reg, unitMode_reg};
      end else if (wrHit(regAddr, CSP_OFF_CMP_LO)) begin
        regRdData <= cmpLow_reg;
      end else if (wrHit(regAddr, CSP_OFF_CMP_HI)) begin
        regRdData <= cmpHigh_reg;
      end else if (wrHit(regAddr, CSP_OFF_T1_LO)) begin
        regRdData <= t1Count_reg[7:0];
      end else if (wrHit(regAddr, CSP_OFF_T1_HI)) begin
        regRdData <= t1Count_reg[15:8];
      end else if (wrHit(regAddr, CSP_OFF_T2_CNT)) begin
        regRdData <= t2Count_reg;
      end else if (wrHit(regAddr, CSP_OFF_PERIOD)) begin
        regRdData <= period_reg;
      end else if (wrHit(regAddr, CSP_OFF_T2_CTRL)) begin
        regRdData <= {1'b0, t2PostSel_reg, t2Run_reg, t2PreSel_reg};
      end else if (wrHit(regAddr, CSP_OFF_FLAGS)) begin
        regRdData <= {6'h00, t2Match_reg, t1Ovf_reg};
      end else if (wrHit(regAddr, CSP_OFF_AUX)) begin
        regRdData <= {6'h00, pinDir_reg, t1Run_reg};
      end else begin
        regRdData <= CSP_RST_ZERO;
      end
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic t1Wr;
  assign t1Wr = regWr && (wrHit(regAddr, CSP_OFF_T1_LO) || wrHit(regAddr, CSP_OFF_T1_HI));

  a_trig_clears_t1: assert property (
    specialTrigger && t1Tick && !t1Wr |=> t1Count_reg == 16'h0000)
    else $error("Timer1 not cleared on tick after trigger");

  a_trig_holds_t1: assert property (
    specialTrigger && !t1Tick && !t1Wr |=> $stable(t1Count_reg))
    else $error("Timer1 changed at the match itself");

  a_trig_no_ovf: assert property (
    specialTrigger && t1Tick && !t1Ovf_reg |=> !t1Ovf_reg)
    else $error("Trigger clear set the overflow flag");

  a_trig_on_match: assert property (
    specialMode && !sleepMode && t1Count_reg == {cmpHigh_reg, cmpLow_reg} |-> specialTrigger)
    else $error("Trigger missing on match");

  a_adc_needs_enable: assert property (
    adcStart |-> specialTrigger && adcEnabled)
    else $error("Conversion start without trigger or enable");

  a_special_no_drive: assert property (
    specialMode |-> !pinOe)
    else $error("Pin driven in trigger mode");

  a_reload_sets_pin: assert property (
    pwmMode && periodReload && dutyNext != 10'h000 ##1 pwmMode |->
      pwmLevel_reg && cmpHigh_reg == $past(cmpLow_reg))
    else $error("Period reload did not set pin or load duty");

  a_zero_duty_low: assert property (
    pwmMode && periodReload && dutyNext == 10'h000 |=> !pwmLevel_reg)
    else $error("Zero duty drove pin high");

  a_duty_match_low: assert property (
    pwmMode && !periodReload && timeBase == activeDuty |=> !pwmLevel_reg)
    else $error("Pin not cleared at duty match");

  a_cmphi_readonly: assert property (
    pwmMode && !periodReload ##0 regWr && wrHit(regAddr, CSP_OFF_CMP_HI) |=>
      $stable(cmpHigh_reg))
    else $error("Compare high written in PWM mode");

  a_period_wraps: assert property (
    periodReload && !(regWr && wrHit(regAddr, CSP_OFF_T2_CNT)) |=> t2Count_reg == 8'h00)
    else $error("Timer2 did not wrap at period");

  a_off_releases: assert property (
    unitMode_reg == CSP_MODE_OFF |-> !pinOe ##1 (!pwmLevel_reg && dutyLatch_reg == 2'h0))
    else $error("Unit off did not reset state");

  a_sleep_freeze: assert property (
    sleepMode && !regWr |=> $stable(t2Count_reg) && $stable(t1Count_reg))
    else $error("Timers moved in sleep");

  a_sleep_no_trig: assert property (
    sleepMode |-> !specialTrigger && !adcStart)
    else $error("Trigger fired during sleep");

  a_rise_on_reload: assert property (
    !pwmLevel_reg ##1 pwmLevel_reg |-> $past(periodReload))
    else $error("Pin rose away from a period reload");

  c_trig_reset: cover property (specialTrigger && t1Tick);
  c_pwm_reload: cover property (pwmMode && periodReload && dutyNext != 10'h000);
  c_pwm_fall: cover property (pwmMode && pwmLevel_reg ##1 !pwmLevel_reg);
  c_trig_skip: cover property (specialTrigger ##1 !specialTrigger && specialMode);
  c_sleep_hold: cover property (sleepMode && t1Run_reg && specialMode);

endmodule
`default_nettype wire

// [testbench/csp_pin_load.sv]
`timescale 1ns/10ps
`default_nettype none
module csp_pin_load (
  // Clock
  input wire logic sys_clk,
  // Pin as the unit drives it
  input wire logic pinOut,
  input wire logic pinOe,
  // Wire level and last measured pulse
  output logic pinLevel,
  output logic [15:0] highCyc,
  output logic [15:0] perCyc
);
  logic lastReg = 1'b0;
  logic drvReg = 1'b1;
  logic [15:0] hiCnt = 16'h0000;
  logic [15:0] perCnt = 16'h0000;
  // Released pin shows the inverse of its last driven level, so stale data cannot pass
  assign pinLevel = pinOe ? pinOut : ~drvReg;
  // Measure high time at each fall and period between rises
  always_ff @(posedge sys_clk) begin
    lastReg <= pinLevel;
    if (pinOe) drvReg <= pinOut;
    if (pinLevel && !lastReg) begin
      perCyc <= perCnt;
      perCnt <= 16'h0001;
      hiCnt <= 16'h0001;
    end else begin
      perCnt <= perCnt + 16'h0001;
      if (pinLevel) hiCnt <= hiCnt + 16'h0001;
    end
    if (!pinLevel && lastReg) highCyc <= hiCnt;
  end
endmodule
`default_nettype wire

// [testbench/tb_csp_unit.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_csp_unit;
  import csp_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] v;} csp_row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic sleepMode = 1'b0;
  logic adcEnabled = 1'b1;
  logic specialTrigger, adcStart, pinOut, pinOe, pinLevel;
  logic [15:0] highCyc, perCyc;
  logic [7:0] d, e;
  csp_row_t rows [11];
  int nMismatch = 0;
  int testsRun = 0;
  int cyc = 0;
  int n;

  csp_unit dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sleepMode(sleepMode), .adcEnabled(adcEnabled), .specialTrigger(specialTrigger),
    .adcStart(adcStart), .pinOut(pinOut), .pinOe(pinOe));
  csp_pin_load load_u (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe),
    .pinLevel(pinLevel), .highCyc(highCyc), .perCyc(perCyc));

  // 20 MHz system clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, well above the under one thousand cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    testsRun++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      nMismatch++;
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    v = regRdData;
  endtask

  // Trigger is combinational, so look mid-cycle
  task automatic waitTrig();
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (specialTrigger !== 1'b1 && n < 400);
    chk("trigSeen", 1'b1, specialTrigger);
  endtask

  initial begin
    rows = '{'{CSP_OFF_CTRL, CSP_RST_ZERO}, '{CSP_OFF_CMP_LO, CSP_RST_ZERO},
      '{CSP_OFF_CMP_HI, CSP_RST_ZERO}, '{CSP_OFF_T1_LO, CSP_RST_ZERO},
      '{CSP_OFF_T1_HI, CSP_RST_ZERO}, '{CSP_OFF_T2_CNT, CSP_RST_ZERO},
      '{CSP_OFF_PERIOD, CSP_RST_PERIOD}, '{CSP_OFF_T2_CTRL, CSP_RST_ZERO},
      '{CSP_OFF_FLAGS, CSP_RST_ZERO}, '{CSP_OFF_AUX, CSP_RST_AUX}, '{4'ha, 8'h00}};
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    chk("pinOeRst", 1'b0, pinOe);
    // Reset values, unmapped address last
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      chk("resetValue", rows[i].v, d);
    end
    // Compare pair as Timer1 period, pin driver allowed but mode holds it off
    wr(CSP_OFF_CMP_LO, 8'h05);
    wr(CSP_OFF_CTRL, 8'h0b);
    wr(CSP_OFF_AUX, 8'h01);
    waitTrig();
    chk("adcStart", 1'b1, adcStart);
    chk("pinOeTrig", 1'b0, pinOe);
    // Match stands for the whole Timer1 tick, four clocks, before the clear
    n = 0;
    while (specialTrigger === 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("trigHold", 16'd4, 16'(n));
    rd(CSP_OFF_T1_LO, d);
    chk("t1Cleared", 1'b1, d <= 8'h01);
    rd(CSP_OFF_FLAGS, d);
    chk("t1OvfFlag", 1'b0, d[CSP_FLAG_T1_OVF]);
    // Second match with converter off, then remove the match before the tick
    @(posedge sys_clk);
    adcEnabled <= 1'b0;
    waitTrig();
    chk("adcStartOff", 1'b0, adcStart);
    wr(CSP_OFF_CMP_LO, 8'h40);
    repeat (8) @(posedge sys_clk);
    rd(CSP_OFF_T1_LO, d);
    chk("t1Skip", 1'b1, d >= 8'h06 && d <= 8'h08);
    // Sleep freezes Timer1 while it is running
    @(posedge sys_clk);
    sleepMode <= 1'b1;
    rd(CSP_OFF_T1_LO, e);
    repeat (20) @(posedge sys_clk);
    rd(CSP_OFF_T1_LO, d);
    chk("t1Sleep", e, d);
    @(posedge sys_clk);
    sleepMode <= 1'b0;
    // PWM setup with pin released until Timer2 has matched once
    wr(CSP_OFF_AUX, 8'h02);
    wr(CSP_OFF_PERIOD, 8'h03);
    wr(CSP_OFF_CTRL, 8'h2e);
    wr(CSP_OFF_CMP_LO, 8'h01);
    wr(CSP_OFF_FLAGS, 8'h03);
    wr(CSP_OFF_T2_CTRL, 8'h04);
    n = 0;
    do begin
      rd(CSP_OFF_FLAGS, d);
      n++;
    end while (d[CSP_FLAG_T2_MATCH] !== 1'b1 && n < 50);
    chk("t2Match", 1'b1, d[CSP_FLAG_T2_MATCH]);
    wr(CSP_OFF_AUX, 8'h00);
    @(negedge sys_clk);
    chk("pinOePwm", 1'b1, pinOe);
    repeat (48) @(posedge sys_clk);
    chk("highDuty6", 16'd6, highCyc);
    chk("period1to1", 16'd16, perCyc);
    wr(CSP_OFF_CMP_HI, 8'h55);
    rd(CSP_OFF_CMP_HI, d);
    chk("cmpHiRo", 8'h01, d);
    // New duty only after a reload, other upper-mode encoding
    wr(CSP_OFF_CMP_LO, 8'h02);
    wr(CSP_OFF_CTRL, 8'h0c);
    repeat (48) @(posedge sys_clk);
    chk("highDuty8", 16'd8, highCyc);
    rd(CSP_OFF_CMP_HI, d);
    chk("cmpHiLoad", 8'h02, d);
    // 1:4 prescale with a postscale that must not matter
    wr(CSP_OFF_T2_CTRL, 8'h1d);
    repeat (200) @(posedge sys_clk);
    chk("highPre4", 16'd32, highCyc);
    chk("periodPre4", 16'd64, perCyc);
    // Zero duty never sets the pin
    wr(CSP_OFF_CMP_LO, 8'h00);
    repeat (130) @(posedge sys_clk);
    n = 0;
    repeat (70) begin
      @(negedge sys_clk);
      if (pinLevel !== 1'b0) n++;
    end
    chk("zeroDuty", 16'h0000, 16'(n));
    // Clearing control gives the pin back
    wr(CSP_OFF_CTRL, 8'h00);
    @(negedge sys_clk);
    chk("pinOeOff", 1'b0, pinOe);
    summarize();
  end
endmodule
`default_nettype wire
